// ==== core/dsc_pkg.sv ====
// Functional notes
// - In 8-pixel units the cursor is 8 wide; bit 5 repeats it onto the cell.
// - High code bit 5: 0 half-width or left half, 1 right half of wide glyph.
// - Byte-group bit 0 clear gives two-byte cells; bits 7,6,5 are blink, reverse, continue.
// - Two-byte cell with bit 6 set is black on white, else white on black.
// - Mode bit 5 set blinks bit-7 cells over 32 fields; clear, bit 7 is background intensity.
// - Byte-group bit 1 takes foreground intensity per pixel from high lanes, fonts 6-8, 8N or 16N.
// - Clock field 00 first pin, 01 second pin, 1x on-chip oscillator; reset 00.
// - Border inhibit forces black border whatever colour is programmed.
// - Host-width bit: 1 is 16-bit host; its even bytes pass on the low lanes.
// - 16-bit video bus: even bytes low lanes, odd high; 8-bit bus: all low.
// - During writes the unused lane group floats; 16-bit host odd writes drive none.
// - Narrow-bus bit: 1 is 8-bit, 0 is 16-bit; reset value from width strap.
// - Memory-type bit: 1 static, 0 dynamic; reset value from memory-type strap.
// - Compat bit: 1 mono-card mode, 0 colour mode; reset value from raster bit 4 pin.
// - Mono-card mode forces colour bits 3..0 to 7H and mode bits 0,2,4 to 1.
// - Mode bit 7 and control bits 0,1 act only in mono-card mode, else zero.
// - Video address is 4K text or 32K graphics in mono mode, 16K in colour; rest 0.
// - Sync-mode bit 1 passes programmed sync widths; 0 outputs narrowed pulses.
// - Sync-mode bit 1 makes vertical sync active low, 0 active high.
// - Sync-mode 0 caps horizontal sync at 4 characters, vertical at 3 lines.
// - Byte-group bit 0 set gives four-byte cells with a full attribute byte.
package dsc_pkg;
	// Register offsets
	localparam logic [7:0] OFF_SYS_CONFIG  = 8'h25;
	localparam logic [7:0] OFF_MODE        = 8'h30;
	localparam logic [7:0] OFF_COLOUR      = 8'h31;
	localparam logic [7:0] OFF_CTRL_ID     = 8'h32;
	localparam logic [7:0] OFF_TEXT_FORMAT = 8'h33;
	// System configuration field positions
	localparam int CFG_CLK_LO   = 0;
	localparam int CFG_CLK_HI   = 1;
	localparam int CFG_BORDER_INHIBIT     = 2;
	localparam int CFG_HOST16   = 3;
	localparam int CFG_NARROW   = 4;
	localparam int CFG_STATIC   = 5;
	localparam int CFG_MONO     = 6;
	localparam int CFG_SYNCMODE = 7;
	// Mode register bits
	localparam int MODE_GFX   = 1;
	localparam int MODE_BLINK = 5;
	localparam int MODE_PAGE  = 7;
	localparam logic [7:0] MODE_MONO_FORCE = 8'h15;
	localparam logic [7:0] CTRL_MONO_MASK  = 8'h03;
	localparam logic [3:0] COLOUR_MONO     = 4'h7;
	// Text format register fields
	localparam int TF_BYTE_GROUP_FIELD_BIT0 = 0;
	localparam int TF_BYTE_GROUP_FIELD_BIT1 = 1;
	localparam int TF_FON_LO = 2;
	localparam logic [2:0] FON_8PEL   = 3'h2;
	localparam logic [2:0] FON_8N     = 3'h5;
	localparam logic [2:0] FON_16N    = 3'h6;
	// High code byte attribute bits
	localparam int HI_BLINK  = 7;
	localparam int HI_REV    = 6;
	localparam int HI_CONT   = 5;
	// Reset values
	localparam logic [7:0] SYS_CONFIG_RST = 8'h00;
	localparam logic [7:0] REG_RST        = 8'h00;
	// Address size masks
	localparam logic [15:0] AMASK_MONO_TEXT = 16'h0FFF;
	localparam logic [15:0] AMASK_MONO_GFX  = 16'h7FFF;
	localparam logic [15:0] AMASK_COLOUR    = 16'h3FFF;
	// Sync caps and blink period
	localparam logic [3:0] HSYNC_CAP_CHARS = 4'h4;
	localparam logic [3:0] VSYNC_CAP_LINES = 4'h3;
	localparam int BLINK_FIELDS = 32;
	localparam int BLINK_W = $clog2(BLINK_FIELDS);
	localparam logic [3:0] RGBI_WHITE = 4'h7;
	localparam logic [3:0] RGBI_BLACK = 4'h0;

	// Host access to video memory
	typedef struct packed {
		logic       valid;
		logic       write;
		logic       a0;
		logic [7:0] wdata;
	} dsc_host_req_type;

	// One text pixel as presented by the fetch logic
	typedef struct packed {
		logic       valid;
		logic       cell_start;
		logic [7:0] code_hi;
		logic [7:0] attr;
		logic       glyph;
		logic       glyph_int;
		logic       cursor;
	} dsc_pixel_type;
endpackage

// ==== core/dsc_top.sv ====
`timescale 1ns/10ps
module dsc_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic                      SYS_CLK,
	input  wire logic                      RESET_N,
	input  wire logic [ADDR_W-1:0]         REG_ADDR,
	input  wire logic [7:0]                REG_WDATA,
	input  wire logic                      REG_WR,
	input  wire logic                      REG_RD,
	output logic [7:0]                     REG_RDATA,
	input  wire logic                      WIDTH_STRAP_PIN_N,
	input  wire logic                      MEMORY_TYPE_STRAP_PIN_N,
	input  wire logic                      RASTER_BIT4_PIN,
	output logic                           CLK_USE_SECOND_PIN,
	output logic                           CLK_OSC_ENABLE,
	input  wire dsc_pkg::dsc_host_req_type HOST_REQ,
	output logic [7:0]                     HOST_RDATA,
	output logic                           HOST_RVALID,
	input  wire logic [15:0]               VD_IN,
	output logic [15:0]                    VD_OUT,
	output logic                           VD_LOW_OE_N,
	output logic                           VD_HIGH_OE_N,
	input  wire logic [15:0]               VADDR_IN,
	output logic [15:0]                    VADDR_OUT,
	input  wire dsc_pkg::dsc_pixel_type    PIXEL_IN,
	input  wire logic                      BORDER_ACTIVE,
	input  wire logic                      FIELD_STROBE,
	output logic [3:0]                     PIXEL_RGBI,
	input  wire logic                      HSYNC_RAW,
	input  wire logic                      VSYNC_RAW,
	input  wire logic                      CHAR_STROBE,
	input  wire logic                      LINE_STROBE,
	output logic                           HSYNC_OUT,
	output logic                           VSYNC_PIN
);
	import dsc_pkg::*;

	// Refuse an address port too narrow to reach the register offsets
	if (ADDR_W < 8) begin : g_addr_w_check
		$error("ADDR_W must be at least 8");
	end

	logic       rst_meta_q;
	logic       rst_n_q;
	logic       strap_pending_q;
	logic [2:0] strap_q;
	logic [7:0] sys_cfg_q;
	logic [7:0] mode_q;
	logic [7:0] colour_q;
	logic [7:0] ctrl_q;
	logic [7:0] tfmt_q;
	logic [7:0] mode_eff;
	logic [7:0] colour_eff;
	logic [7:0] ctrl_eff;
	logic       mono;
	logic       narrow;
	logic       host16;
	logic       sync_mode;
	logic       wr_hit;

	// Offset match for the register port
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == ADDR_W'(off));
	endfunction

	// Reset release through two flip-flops
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	assign mono      = sys_cfg_q[CFG_MONO];
	assign narrow    = sys_cfg_q[CFG_NARROW];
	assign host16    = sys_cfg_q[CFG_HOST16];
	assign sync_mode = sys_cfg_q[CFG_SYNCMODE];
	assign wr_hit    = REG_WR && hit(REG_ADDR, OFF_SYS_CONFIG);

	// Strap levels follow their pins while reset is held and freeze on release;
	// no reset here, since a reset branch may only load constants
	always_ff @(posedge SYS_CLK) begin
		if (!rst_n_q) begin
			strap_q <= {RASTER_BIT4_PIN, MEMORY_TYPE_STRAP_PIN_N, WIDTH_STRAP_PIN_N};
		end
	end

	// Captured straps land in the first cycle after release, then only software changes them.
	// The strap pins act at their level: a high width strap selects the narrow bus.
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			strap_pending_q <= 1'b1;
			sys_cfg_q       <= SYS_CONFIG_RST;
		end else if (strap_pending_q) begin
			strap_pending_q         <= 1'b0;
			sys_cfg_q[CFG_NARROW]   <= strap_q[0];
			sys_cfg_q[CFG_STATIC]   <= strap_q[1];
			sys_cfg_q[CFG_MONO]     <= strap_q[2];
		end else if (wr_hit) begin
			sys_cfg_q <= REG_WDATA;
		end
	end

	// Auxiliary registers written by software
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_q   <= REG_RST;
			colour_q <= REG_RST;
			ctrl_q   <= REG_RST;
			tfmt_q   <= REG_RST;
		end else if (REG_WR) begin
			if (hit(REG_ADDR, OFF_MODE)) begin
				mode_q <= REG_WDATA;
			end
			if (hit(REG_ADDR, OFF_COLOUR)) begin
				colour_q <= REG_WDATA;
			end
			if (hit(REG_ADDR, OFF_CTRL_ID)) begin
				ctrl_q <= REG_WDATA;
			end
			if (hit(REG_ADDR, OFF_TEXT_FORMAT)) begin
				tfmt_q <= REG_WDATA;
			end
		end
	end

	// Effective values after compatibility forcing
	always_comb begin
		if (mono) begin
			mode_eff   = mode_q | MODE_MONO_FORCE;
			colour_eff = {colour_q[7:4], COLOUR_MONO};
			ctrl_eff   = ctrl_q;
		end else begin
			mode_eff             = mode_q;
			mode_eff[MODE_PAGE]  = 1'b0;
			colour_eff           = colour_q;
			ctrl_eff             = ctrl_q & ~CTRL_MONO_MASK;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			if (hit(REG_ADDR, OFF_SYS_CONFIG)) begin
				REG_RDATA <= sys_cfg_q;
			end else if (hit(REG_ADDR, OFF_MODE)) begin
				REG_RDATA <= mode_eff;
			end else if (hit(REG_ADDR, OFF_COLOUR)) begin
				REG_RDATA <= colour_eff;
			end else if (hit(REG_ADDR, OFF_CTRL_ID)) begin
				REG_RDATA <= ctrl_eff;
			end else if (hit(REG_ADDR, OFF_TEXT_FORMAT)) begin
				REG_RDATA <= tfmt_q;
			end else begin
				REG_RDATA <= 8'h00;
			end
		end else begin
			REG_RDATA <= 8'h00;
		end
	end

	// Master clock source selection
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			CLK_USE_SECOND_PIN <= 1'b0;
			CLK_OSC_ENABLE     <= 1'b0;
		end else begin
			CLK_OSC_ENABLE     <= sys_cfg_q[CFG_CLK_HI];
			CLK_USE_SECOND_PIN <= ~sys_cfg_q[CFG_CLK_HI] & sys_cfg_q[CFG_CLK_LO];
		end
	end

	// Host byte steering onto the video data lanes
	// Odd bytes of a wide host reach memory round the device, so no lane is driven for them
	logic use_high;
	logic drive_any;
	logic odd_wide_host;
	assign odd_wide_host = host16 && HOST_REQ.a0;
	assign use_high      = HOST_REQ.a0 && !narrow && !host16;
	assign drive_any     = HOST_REQ.valid && HOST_REQ.write && !odd_wide_host;

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			VD_OUT       <= 16'h0000;
			VD_LOW_OE_N  <= 1'b1;
			VD_HIGH_OE_N <= 1'b1;
		end else begin
			VD_OUT       <= {HOST_REQ.wdata, HOST_REQ.wdata};
			VD_LOW_OE_N  <= ~(drive_any && !use_high);
			VD_HIGH_OE_N <= ~(drive_any && use_high);
		end
	end

	// Host read data taken from the lane group that holds the byte
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			HOST_RDATA  <= 8'h00;
			HOST_RVALID <= 1'b0;
		end else begin
			HOST_RVALID <= HOST_REQ.valid && !HOST_REQ.write && !odd_wide_host;
			HOST_RDATA  <= use_high ? VD_IN[15:8] : VD_IN[7:0];
		end
	end

	// Video address sized to the compatibility mode
	logic [15:0] amask;
	always_comb begin
		if (!mono) begin
			amask = AMASK_COLOUR;
		end else if (mode_eff[MODE_GFX]) begin
			amask = AMASK_MONO_GFX;
		end else begin
			amask = AMASK_MONO_TEXT;
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			VADDR_OUT <= 16'h0000;
		end else begin
			VADDR_OUT <= VADDR_IN & amask;
		end
	end

	// Field counter for the blink attribute
	// Its top bit gives half the period lit and half dark
	logic [BLINK_W-1:0] field_cnt_q;
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			field_cnt_q <= '0;
		end else if (FIELD_STROBE) begin
			field_cnt_q <= field_cnt_q + 1'b1;
		end
	end

	// Cursor continuation across 8-pixel units
	logic cont_q;
	logic cursor_run_q;
	logic cursor_now;
	logic two_byte;
	logic int_font_ok;
	logic [2:0] fon;
	assign two_byte = !tfmt_q[TF_BYTE_GROUP_FIELD_BIT0];
	assign fon      = tfmt_q[TF_FON_LO +: 3];
	assign int_font_ok = (fon <= FON_8PEL) || (fon == FON_8N) || (fon == FON_16N);

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cursor_run_q <= 1'b0;
			cont_q       <= 1'b0;
		end else if (PIXEL_IN.valid && PIXEL_IN.cell_start) begin
			// Right half of a wide glyph follows the cursor of its left half
			cont_q       <= PIXEL_IN.code_hi[HI_CONT] && cursor_run_q;
			cursor_run_q <= PIXEL_IN.cursor;
		end else if (PIXEL_IN.valid) begin
			cursor_run_q <= cursor_run_q | PIXEL_IN.cursor;
		end
	end

	// Cursor either from the address compare or copied from the left unit
	assign cursor_now = PIXEL_IN.cursor ||
		(PIXEL_IN.code_hi[HI_CONT] &&
		 (PIXEL_IN.cell_start ? cursor_run_q : cont_q));

	// Pixel colour selection
	logic [3:0] fg;
	logic [3:0] bg;
	logic       on;
	logic       blink_off;
	always_comb begin
		blink_off = 1'b0;
		if (two_byte) begin
			// Simplified attribute in the high code byte
			if (PIXEL_IN.code_hi[HI_REV]) begin
				fg = RGBI_BLACK;
				bg = RGBI_WHITE;
			end else begin
				fg = RGBI_WHITE;
				bg = RGBI_BLACK;
			end
			if (mode_eff[MODE_BLINK]) begin
				blink_off = PIXEL_IN.code_hi[HI_BLINK] && field_cnt_q[BLINK_W-1];
			end else begin
				bg[3] = PIXEL_IN.code_hi[HI_BLINK];
			end
			fg[3] = 1'b0;
		end else begin
			// Four-byte cell carries a full attribute byte
			fg = PIXEL_IN.attr[3:0];
			bg = PIXEL_IN.attr[7:4];
			if (mode_eff[MODE_BLINK]) begin
				bg[3]     = 1'b0;
				blink_off = PIXEL_IN.attr[7] && field_cnt_q[BLINK_W-1];
			end
		end
		if (tfmt_q[TF_BYTE_GROUP_FIELD_BIT1] && int_font_ok) begin
			fg[3] = PIXEL_IN.glyph_int;
		end
		on = (PIXEL_IN.glyph && !blink_off) ^ cursor_now;
	end

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			PIXEL_RGBI <= RGBI_BLACK;
		end else if (BORDER_ACTIVE) begin
			PIXEL_RGBI <= sys_cfg_q[CFG_BORDER_INHIBIT] ? RGBI_BLACK : colour_eff[3:0];
		end else if (PIXEL_IN.valid) begin
			PIXEL_RGBI <= on ? fg : bg;
		end else begin
			PIXEL_RGBI <= RGBI_BLACK;
		end
	end

	// Sync width counters
	// They stop at the cap so a long programmed pulse cannot wrap and reopen
	logic [3:0] hcnt_q;
	logic [3:0] vcnt_q;
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			hcnt_q <= 4'h0;
		end else if (!HSYNC_RAW) begin
			hcnt_q <= 4'h0;
		end else if (CHAR_STROBE && hcnt_q != HSYNC_CAP_CHARS) begin
			hcnt_q <= hcnt_q + 4'h1;
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			vcnt_q <= 4'h0;
		end else if (!VSYNC_RAW) begin
			vcnt_q <= 4'h0;
		end else if (LINE_STROBE && vcnt_q != VSYNC_CAP_LINES) begin
			vcnt_q <= vcnt_q + 4'h1;
		end
	end

	// Sync outputs: exact width or capped, and vertical polarity
	logic hs_act;
	logic vs_act;
	assign hs_act = HSYNC_RAW && (sync_mode || hcnt_q < HSYNC_CAP_CHARS);
	assign vs_act = VSYNC_RAW && (sync_mode || vcnt_q < VSYNC_CAP_LINES);

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			HSYNC_OUT <= 1'b0;
			VSYNC_PIN <= 1'b0;
		end else begin
			HSYNC_OUT <= hs_act;
			VSYNC_PIN <= sync_mode ? ~vs_act : vs_act;
		end
	end

endmodule

// ==== test/dsc_top_sva.sv ====
`timescale 1ns/10ps
module dsc_top_chk #(
	parameter int ADDR_W = 8
) (
	input wire logic                      SYS_CLK,
	input wire logic                      RESET_N,
	input wire logic [ADDR_W-1:0]         REG_ADDR,
	input wire logic [7:0]                REG_WDATA,
	input wire logic                      REG_WR,
	input wire logic                      REG_RD,
	input wire logic [7:0]                REG_RDATA,
	input wire logic                      CLK_USE_SECOND_PIN,
	input wire logic                      CLK_OSC_ENABLE,
	input wire dsc_pkg::dsc_host_req_type HOST_REQ,
	input wire logic                      HOST_RVALID,
	input wire logic [15:0]               VD_OUT,
	input wire logic                      VD_LOW_OE_N,
	input wire logic                      VD_HIGH_OE_N,
	input wire logic [15:0]               VADDR_IN,
	input wire logic [15:0]               VADDR_OUT,
	input wire logic                      HSYNC_RAW,
	input wire logic                      HSYNC_OUT
);
	import dsc_pkg::*;
	// All checks run on the system clock and rest while reset is low
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESET_N);

	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
		else $error("read data outside its slot");
	a_clk_second_sel: assert property ((REG_WR && REG_ADDR == OFF_SYS_CONFIG
		&& REG_WDATA[1:0] == 2'b01) ##1 !REG_WR ##1 !REG_WR |-> CLK_USE_SECOND_PIN)
		else $error("second clock pin not selected");
	a_clk_one_src: assert property (!(CLK_USE_SECOND_PIN && CLK_OSC_ENABLE))
		else $error("two clock sources at once");
	a_lane_single: assert property (VD_LOW_OE_N || VD_HIGH_OE_N)
		else $error("both lane groups driven");
	a_low_drive_cause: assert property (!VD_LOW_OE_N |-> $past(HOST_REQ.valid && HOST_REQ.write)
		&& VD_OUT[7:0] == $past(HOST_REQ.wdata))
		else $error("low lanes driven without write");
	a_high_drive_cause: assert property (!VD_HIGH_OE_N |-> $past(HOST_REQ.valid && HOST_REQ.a0)
		&& VD_OUT[15:8] == $past(HOST_REQ.wdata))
		else $error("high lanes driven without odd write");
	a_rvalid_cause: assert property (HOST_RVALID |-> $past(HOST_REQ.valid && !HOST_REQ.write))
		else $error("read answer without read");
	a_addr_low_pass: assert property (VADDR_OUT[11:0] == $past(VADDR_IN[11:0]) && !VADDR_OUT[15])
		else $error("video address bits wrong");
	a_hsync_inside: assert property (HSYNC_OUT |-> $past(HSYNC_RAW))
		else $error("sync wider than programmed");

	// Main scenarios reached
	c_cfg_write: cover property (REG_WR && REG_ADDR == OFF_SYS_CONFIG);
	c_host_read: cover property (HOST_RVALID);
	c_hsync: cover property ($fell(HSYNC_OUT));
endmodule

bind dsc_top dsc_top_chk #(.ADDR_W(ADDR_W)) i_dsc_top_chk (.SYS_CLK, .RESET_N, .REG_ADDR,
	.REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .CLK_USE_SECOND_PIN, .CLK_OSC_ENABLE, .HOST_REQ,
	.HOST_RVALID, .VD_OUT, .VD_LOW_OE_N, .VD_HIGH_OE_N, .VADDR_IN, .VADDR_OUT, .HSYNC_RAW,
	.HSYNC_OUT);

// ==== test/dsc_vmem_model.sv ====
`timescale 1ns/10ps
module dsc_vmem_model (
	input wire logic        clk,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic        low_we_n,
	input wire logic        high_we_n,
	output logic [15:0]     rdata
);
	logic [15:0] mem [0:15];
	// Each lane group is stored only while the device drives it
	always_ff @(posedge clk) begin
		if (!low_we_n) begin
			mem[addr[3:0]][7:0] <= wdata[7:0];
		end
		if (!high_we_n) begin
			mem[addr[3:0]][15:8] <= wdata[15:8];
		end
	end
	// Both lane groups always present the addressed word
	assign rdata = mem[addr[3:0]];
endmodule

// ==== test/dsc_top_tb.sv ====
`timescale 1ns/10ps
module dsc_top_tb;
	import dsc_pkg::*;
	logic             SYS_CLK = 1'b0;
	logic             RESET_N = 1'b0;
	logic [7:0]       REG_ADDR = 8'h00;
	logic [7:0]       REG_WDATA = 8'h00;
	logic             REG_WR = 1'b0;
	logic             REG_RD = 1'b0;
	logic [7:0]       REG_RDATA;
	logic             WIDTH_STRAP_PIN_N = 1'b0;
	logic             MEMORY_TYPE_STRAP_PIN_N = 1'b0;
	logic             RASTER_BIT4_PIN = 1'b0;
	logic             CLK_USE_SECOND_PIN;
	logic             CLK_OSC_ENABLE;
	dsc_host_req_type HOST_REQ = '0;
	logic [7:0]       HOST_RDATA;
	logic             HOST_RVALID;
	logic [15:0]      VD_IN;
	logic [15:0]      VD_OUT;
	logic             VD_LOW_OE_N;
	logic             VD_HIGH_OE_N;
	logic [15:0]      VADDR_IN = 16'h0000;
	logic [15:0]      VADDR_OUT;
	dsc_pixel_type    PIXEL_IN = '0;
	logic             BORDER_ACTIVE = 1'b0;
	logic             FIELD_STROBE = 1'b0;
	logic [3:0]       PIXEL_RGBI;
	logic             HSYNC_RAW = 1'b0;
	logic             VSYNC_RAW = 1'b0;
	logic             CHAR_STROBE = 1'b0;
	logic             LINE_STROBE = 1'b0;
	logic             HSYNC_OUT;
	logic             VSYNC_PIN;
	int               n_mismatch = 0;
	int               compares = 0;

	dsc_top #(.ADDR_W(8)) i_dsc_top (.SYS_CLK, .RESET_N, .REG_ADDR, .REG_WDATA, .REG_WR,
		.REG_RD, .REG_RDATA, .WIDTH_STRAP_PIN_N, .MEMORY_TYPE_STRAP_PIN_N, .RASTER_BIT4_PIN,
		.CLK_USE_SECOND_PIN, .CLK_OSC_ENABLE, .HOST_REQ, .HOST_RDATA, .HOST_RVALID, .VD_IN,
		.VD_OUT, .VD_LOW_OE_N, .VD_HIGH_OE_N, .VADDR_IN, .VADDR_OUT, .PIXEL_IN, .BORDER_ACTIVE,
		.FIELD_STROBE, .PIXEL_RGBI, .HSYNC_RAW, .VSYNC_RAW, .CHAR_STROBE, .LINE_STROBE,
		.HSYNC_OUT, .VSYNC_PIN);
	dsc_vmem_model i_dsc_vmem_model (.clk(SYS_CLK), .addr(VADDR_OUT), .wdata(VD_OUT),
		.low_we_n(VD_LOW_OE_N), .high_we_n(VD_HIGH_OE_N), .rdata(VD_IN));

	// 125 MHz system clock
	always #4 SYS_CLK = ~SYS_CLK;

	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rst(input logic w, input logic m, input logic r);
		RESET_N <= 1'b0;
		WIDTH_STRAP_PIN_N <= w;
		MEMORY_TYPE_STRAP_PIN_N <= m;
		RASTER_BIT4_PIN <= r;
		repeat (20) @(posedge SYS_CLK);
		RESET_N <= 1'b1;
		repeat (6) @(posedge SYS_CLK);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		#1;
		chk(16'(REG_RDATA), 16'(e));
	endtask

	// Host byte access; oe is {high, low} active-low drive enables
	task automatic hop(input logic w, input logic a0, input logic [7:0] d,
		input logic [1:0] oe, input logic rv);
		@(posedge SYS_CLK);
		HOST_REQ <= '{1'b1, w, a0, d};
		@(posedge SYS_CLK);
		HOST_REQ.valid <= 1'b0;
		#1;
		chk(16'({VD_HIGH_OE_N, VD_LOW_OE_N, HOST_RVALID}), 16'({oe, rv}));
		if (rv) begin
			chk(16'(HOST_RDATA), 16'(d));
		end
	endtask

	// One pixel cell, judged in the cycle after it is presented
	task automatic pxs(input dsc_pixel_type p, input logic [3:0] e);
		@(posedge SYS_CLK);
		PIXEL_IN <= p;
		@(posedge SYS_CLK);
		PIXEL_IN.valid <= 1'b0;
		#1;
		chk(16'(PIXEL_RGBI), 16'(e));
	endtask

	task automatic pix(input logic [7:0] c, input logic g, input logic [3:0] e);
		pxs('{1'b1, 1'b1, c, 8'h00, g, 1'b0, 1'b0}, e);
	endtask

	// Both sync pulses are raised for ten cycles with a strobe in every cycle
	task automatic hs(input logic [7:0] cfg, input int e, input int ev);
		int n;
		int nv;
		n = 0;
		nv = 0;
		wr(8'h25, cfg);
		CHAR_STROBE <= 1'b1;
		LINE_STROBE <= 1'b1;
		VSYNC_RAW <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge SYS_CLK);
			HSYNC_RAW <= (i < 10);
			VSYNC_RAW <= (i < 10);
			#1;
			n += int'(HSYNC_OUT === 1'b1);
			nv += int'(VSYNC_PIN === ~cfg[7]);
		end
		chk(16'(n), 16'(e));
		chk(16'(nv), 16'(ev));
	endtask

	task automatic vs(input logic raw, input logic e);
		@(posedge SYS_CLK);
		VSYNC_RAW <= raw;
		@(posedge SYS_CLK);
		#1;
		chk(16'(VSYNC_PIN), 16'(e));
	endtask

	task automatic t_straps;
		rst(1'b1, 1'b0, 1'b1);
		rchk(8'h25, 8'h50);
		WIDTH_STRAP_PIN_N <= 1'b0;
		RASTER_BIT4_PIN <= 1'b0;
		rchk(8'h25, 8'h50);
		rst(1'b0, 1'b1, 1'b0);
		rchk(8'h25, 8'h20);
		$display("test straps done");
	endtask

	task automatic t_cfg;
		wr(8'h7F, 8'hFF);
		rchk(8'h7F, 8'h00);
		wr(8'h25, 8'hA5);
		rchk(8'h25, 8'hA5);
		for (int i = 0; i < 4; i++) begin
			wr(8'h25, 8'(i));
			@(posedge SYS_CLK);
			#1;
			chk(16'({CLK_OSC_ENABLE, CLK_USE_SECOND_PIN}), 16'({i >= 2, i == 1}));
		end
		$display("test config done");
	endtask

	task automatic t_lanes;
		wr(8'h25, 8'h00);
		hop(1'b1, 1'b0, 8'hA5, 2'b10, 1'b0);
		hop(1'b1, 1'b1, 8'h5A, 2'b01, 1'b0);
		hop(1'b0, 1'b0, 8'hA5, 2'b11, 1'b1);
		hop(1'b0, 1'b1, 8'h5A, 2'b11, 1'b1);
		wr(8'h25, 8'h10);
		hop(1'b1, 1'b1, 8'h3C, 2'b10, 1'b0);
		hop(1'b0, 1'b0, 8'h3C, 2'b11, 1'b1);
		wr(8'h25, 8'h08);
		hop(1'b1, 1'b0, 8'hC3, 2'b10, 1'b0);
		hop(1'b1, 1'b1, 8'h77, 2'b11, 1'b0);
		hop(1'b0, 1'b0, 8'hC3, 2'b11, 1'b1);
		hop(1'b0, 1'b1, 8'h00, 2'b11, 1'b0);
		$display("test lanes done");
	endtask

	task automatic t_modes;
		VADDR_IN <= 16'hFFFF;
		wr(8'h25, 8'h00);
		rchk(8'h30, 8'h00);
		chk(VADDR_OUT, 16'h3FFF);
		wr(8'h25, 8'h40);
		wr(8'h31, 8'h00);
		wr(8'h30, 8'h80);
		wr(8'h32, 8'h03);
		#1;
		chk(VADDR_OUT, 16'h0FFF);
		rchk(8'h31, 8'h07);
		rchk(8'h30, 8'h95);
		rchk(8'h32, 8'h03);
		wr(8'h30, 8'h02);
		rchk(8'h30, 8'h17);
		chk(VADDR_OUT, 16'h7FFF);
		wr(8'h25, 8'h00);
		wr(8'h30, 8'h80);
		rchk(8'h30, 8'h00);
		rchk(8'h32, 8'h00);
		VADDR_IN <= 16'h0000;
		$display("test modes done");
	endtask

	task automatic t_pix;
		wr(8'h25, 8'h04);
		wr(8'h31, 8'h0F);
		BORDER_ACTIVE <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		#1;
		chk(16'(PIXEL_RGBI), 16'h0000);
		BORDER_ACTIVE <= 1'b0;
		wr(8'h33, 8'h00);
		wr(8'h30, 8'h08);
		pix(8'h00, 1'b1, 4'h7);
		pix(8'h00, 1'b0, 4'h0);
		pix(8'h40, 1'b1, 4'h0);
		pix(8'h40, 1'b0, 4'h7);
		pix(8'h80, 1'b0, 4'h8);
		pix(8'h80, 1'b1, 4'h7);
		wr(8'h30, 8'h28);
		pix(8'h80, 1'b1, 4'h7);
		FIELD_STROBE <= 1'b1;
		repeat (BLINK_FIELDS / 2) @(posedge SYS_CLK);
		FIELD_STROBE <= 1'b0;
		pix(8'h80, 1'b1, 4'h0);
		pix(8'h00, 1'b1, 4'h7);
		$display("test pixels done");
	endtask

	task automatic t_text;
		wr(8'h30, 8'h08);
		pxs('{1'b1, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1}, 4'h7);
		pxs('{1'b1, 1'b1, 8'h20, 8'h00, 1'b0, 1'b0, 1'b0}, 4'h7);
		pxs('{1'b1, 1'b1, 8'h20, 8'h00, 1'b0, 1'b0, 1'b0}, 4'h0);
		wr(8'h33, 8'h02);
		pxs('{1'b1, 1'b1, 8'h00, 8'h00, 1'b1, 1'b1, 1'b0}, 4'hF);
		wr(8'h33, 8'h0E);
		pxs('{1'b1, 1'b1, 8'h00, 8'h00, 1'b1, 1'b1, 1'b0}, 4'h7);
		wr(8'h33, 8'h01);
		pxs('{1'b1, 1'b1, 8'h00, 8'h1E, 1'b1, 1'b0, 1'b0}, 4'hE);
		$display("test text done");
	endtask

	task automatic t_sync;
		hs(8'h00, 4, 3);
		vs(1'b1, 1'b1);
		hs(8'h80, 10, 10);
		vs(1'b0, 1'b1);
		vs(1'b1, 1'b0);
		$display("test sync done");
	endtask

	// Main sequence
	initial begin
		t_straps();
		t_cfg();
		t_lanes();
		t_modes();
		t_pix();
		t_text();
		t_sync();
		final_report();
	end

	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		n_mismatch++;
		final_report();
	end
endmodule
